// ===== inc/acs_pkg.sv
// Constants and types of the conversion sequencer
// Function
// - Idle, single and continuous modes only
// - Single mode write starts one conversion
// - Busy flag high while converting
// - Fast result after one conversion cycle
// - Single SINC3 result after three cycles
// - Select bit picks filter setting done flag
// - Single end returns idle, clears busy
// - SINC3 single run also loads fast result
// - Fast single run may leave SINC3 invalid
// - Continuous mode runs cycles without gaps
// - Continuous fast every cycle, SINC3 from third
// - Both filters update, select only sets done
// - Idle write stops continuous conversions
// - Separate three-byte result sets per filter
// - Polarity bit picks unipolar or bipolar
// - SINC3 spans three latest cycles
// - Buffer control changes only while idle
package acs_pkg;
   // Register addresses on the special function bus
   localparam logic [7:0] ADDR_BUF = 8'hBD;
   localparam logic [7:0] ADDR_CTRL = 8'hE8;
   localparam logic [7:0] ADDR_CFG = 8'hB6;
   localparam logic [7:0] ADDR_MODE = 8'hB7;
   localparam logic [7:0] ADDR_SINC_H = 8'hC4;
   localparam logic [7:0] ADDR_SINC_M = 8'hC3;
   localparam logic [7:0] ADDR_SINC_L = 8'hC2;
   localparam logic [7:0] ADDR_FAST_H = 8'hC7;
   localparam logic [7:0] ADDR_FAST_M = 8'hC6;
   localparam logic [7:0] ADDR_FAST_L = 8'hC5;
   // Field positions
   localparam int CTRL_DONE_BIT = 0;
   localparam int CTRL_BUSY_BIT = 1;
   localparam int CTRL_POL_BIT = 2;
   localparam int CFG_ISEL_BIT = 0;
   // Values after reset
   localparam logic [7:0] BUF_RST = 8'h00;
   localparam logic SYNC_RST = 1'b0;
   // Conversion mode field codes; 2'h3 acts as idle
   localparam logic [1:0] MODE_IDLE = 2'h0;
   localparam logic [1:0] MODE_SINGLE = 2'h1;
   localparam logic [1:0] MODE_CONT = 2'h2;
   // Result word width
   localparam int RES_W = 24;
   // SINC3 history depth in cycles
   localparam logic [1:0] SINC_CYCLES = 2'h3;
   // Sequencer states, Gray along idle, single, continuous
   typedef enum logic [1:0] {
      ACS_IDLE = 2'b00,
      ACS_SINGLE = 2'b01,
      ACS_CONT = 2'b11
   } acs_state_t;
endpackage : acs_pkg

// ===== inc/acs_res_if.sv
// Result hand-off between sequencer and one result store
`timescale 1ns/10ps
interface acs_res_if #(parameter int CW = 8);
   logic load; // One-cycle strobe, new count ready
   logic [CW-1:0] cnt; // Raw count of modulator ones
   logic bipolar; // Output coding select
   logic [acs_pkg::RES_W-1:0] data; // Stored result word
   modport src (output load, output cnt, output bipolar, input data);
   modport dst (input load, input cnt, input bipolar, output data);
endinterface : acs_res_if

// ===== src/acs_result.sv
// Three-byte result store with unipolar or bipolar coding
`timescale 1ns/10ps
module acs_result #(
   parameter int CW = 8,
   parameter int FULL = 64
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   acs_res_if.dst res
);
   typedef struct packed {
      logic [acs_pkg::RES_W-1:0] word; // Held result
   } acs_res_t;
   acs_res_t st_q, st_d;
   logic [acs_pkg::RES_W-1:0] uni; // Plain count
   logic [acs_pkg::RES_W-1:0] bip; // Twice count less full scale

   // Count as wide as the word or wider cannot be coded
   if (CW >= acs_pkg::RES_W || FULL < 1) begin : g_chk
      $error("acs_result: count width or full scale unusable");
   end

   // Bipolar centres mid-scale on zero, two's complement
   always_comb begin
      st_d = st_q;
      uni = acs_pkg::RES_W'(res.cnt);
      bip = (uni << 1) - acs_pkg::RES_W'(FULL);
      if (res.load) begin
         st_d.word = res.bipolar ? bip : uni;
      end
   end

   // Word only changes on a load strobe
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_q <= '0;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   assign res.data = st_q.word;
endmodule : acs_result

// ===== src/acs_sequencer.sv
// Conversion sequencer: modes, filters, flags and registers
`timescale 1ns/10ps
module acs_sequencer #(
   parameter int MOD_DIV = 4, // Clocks per modulator sample
   parameter int DECIM = 64 // Samples per conversion cycle
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic mod_bit, // Modulator data pin
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic [7:0] buf_ctrl, // Input buffer enables
   output logic conv_busy
);
   // Divider and count widths
   localparam int DW = $clog2(MOD_DIV);
   localparam int CW = $clog2(3 * DECIM + 1);

   // Refuse settings the counters cannot serve
   if (MOD_DIV < 2 || DECIM < 2 || CW >= acs_pkg::RES_W) begin : g_chk
      $error("acs_sequencer: MOD_DIV or DECIM out of range");
   end

   // Whole state of the sequencer
   typedef struct packed {
      acs_pkg::acs_state_t st; // Conversion state
      logic [DW-1:0] div; // Modulator clock divider
      logic [CW-1:0] smp; // Samples taken this cycle
      logic [CW-1:0] acc; // Ones seen this cycle
      logic [CW-1:0] h1; // Count one cycle back
      logic [CW-1:0] h2; // Count two cycles back
      logic [1:0] ncyc; // Cycles done, saturating
      logic isel; // Interrupt filter select
      logic pol; // Output polarity bit
      logic done; // Conversion done flag
      logic busy; // Conversion busy flag
      logic [7:0] bufc; // Input buffer control
      logic [7:0] rdata; // Registered read data
   } acs_top_t;
   acs_top_t q, d;

   logic mod_s; // Synchronised modulator bit
   logic wr_mode; // Write to mode register
   logic wr_buf; // Write to buffer register
   logic wr_ctrl; // Write to control register
   logic wr_cfg; // Write to config register
   logic tick; // Modulator sample strobe
   logic end_cyc; // Last sample of a cycle
   logic sinc_ready; // Third or later cycle end
   logic sel_done; // Selected filter finished
   logic [CW-1:0] acc_nxt; // Count with this sample
   logic [CW-1:0] sinc_cnt; // Three-cycle sum
   logic [1:0] mode_rd; // Mode field readback
   logic [7:0] rmux; // Read mux output

   // Pin crosses into the clock domain here
   acs_sync u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .d(mod_bit),
      .q(mod_s)
   );

   // Separate stores for each filter
   acs_res_if #(.CW(CW)) fast_if ();
   acs_res_if #(.CW(CW)) sinc_if ();

   acs_result #(.CW(CW), .FULL(DECIM)) u_fast (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .res(fast_if)
   );

   acs_result #(.CW(CW), .FULL(3 * DECIM)) u_sinc (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .res(sinc_if)
   );

   // Register write decode
   always_comb begin
      wr_mode = sfr_wr && (sfr_addr == acs_pkg::ADDR_MODE);
      wr_buf = sfr_wr && (sfr_addr == acs_pkg::ADDR_BUF);
      wr_ctrl = sfr_wr && (sfr_addr == acs_pkg::ADDR_CTRL);
      wr_cfg = sfr_wr && (sfr_addr == acs_pkg::ADDR_CFG);
   end

   // Cycle timing and filter sums
   always_comb begin
      tick = (q.div == DW'(MOD_DIV - 1));
      // Cycle length is divider times decimation
      end_cyc = tick && (q.smp == CW'(DECIM - 1)) && (q.st != acs_pkg::ACS_IDLE);
      acc_nxt = q.acc + CW'(tick && mod_s);
      // SINC3 sums the three latest cycles
      sinc_cnt = acc_nxt + q.h1 + q.h2;
      sinc_ready = (q.ncyc >= (acs_pkg::SINC_CYCLES - 2'h1));
      // Select bit chooses which end raises done and ends a single run
      sel_done = end_cyc && (q.isel || sinc_ready);
   end

   // Hand counts to the result stores
   always_comb begin
      fast_if.load = end_cyc;
      fast_if.cnt = acc_nxt;
      fast_if.bipolar = q.pol;
      // Fast single runs also write SINC3, not yet valid
      sinc_if.load = end_cyc && (sinc_ready || (q.st == acs_pkg::ACS_SINGLE && q.isel));
      sinc_if.cnt = sinc_cnt;
      sinc_if.bipolar = q.pol;
   end

   // Mode field readback from state
   always_comb begin
      unique case (q.st)
         acs_pkg::ACS_IDLE: mode_rd = acs_pkg::MODE_IDLE;
         acs_pkg::ACS_SINGLE: mode_rd = acs_pkg::MODE_SINGLE;
         acs_pkg::ACS_CONT: mode_rd = acs_pkg::MODE_CONT;
         default: mode_rd = acs_pkg::MODE_IDLE;
      endcase
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      unique case (sfr_addr)
         acs_pkg::ADDR_CTRL: begin
            rmux = 8'h00;
            rmux[acs_pkg::CTRL_DONE_BIT] = q.done;
            rmux[acs_pkg::CTRL_BUSY_BIT] = q.busy;
            rmux[acs_pkg::CTRL_POL_BIT] = q.pol;
         end
         acs_pkg::ADDR_CFG: begin
            rmux = 8'h00;
            rmux[acs_pkg::CFG_ISEL_BIT] = q.isel;
         end
         acs_pkg::ADDR_MODE: rmux = {6'h00, mode_rd};
         acs_pkg::ADDR_BUF: rmux = q.bufc;
         acs_pkg::ADDR_SINC_H: rmux = sinc_if.data[23:16];
         acs_pkg::ADDR_SINC_M: rmux = sinc_if.data[15:8];
         acs_pkg::ADDR_SINC_L: rmux = sinc_if.data[7:0];
         acs_pkg::ADDR_FAST_H: rmux = fast_if.data[23:16];
         acs_pkg::ADDR_FAST_M: rmux = fast_if.data[15:8];
         acs_pkg::ADDR_FAST_L: rmux = fast_if.data[7:0];
         default: rmux = 8'h00;
      endcase
   end

   // Next state of the whole sequencer
   always_comb begin
      d = q;
      d.rdata = rmux;
      // Config and polarity are plain storage
      if (wr_cfg) begin
         d.isel = sfr_wdata[acs_pkg::CFG_ISEL_BIT];
      end
      if (wr_ctrl) begin
         d.pol = sfr_wdata[acs_pkg::CTRL_POL_BIT];
         d.done = q.done && sfr_wdata[acs_pkg::CTRL_DONE_BIT];
      end
      // A finish in the clearing cycle still sets the flag
      if (sel_done) begin
         d.done = 1'b1;
      end
      // Buffer control only takes writes while idle
      if (wr_buf && q.st == acs_pkg::ACS_IDLE) begin
         d.bufc = sfr_wdata;
      end
      // Sample counting only while converting
      if (q.st != acs_pkg::ACS_IDLE) begin
         d.div = tick ? '0 : q.div + DW'(1);
         if (tick) begin
            d.acc = acc_nxt;
            d.smp = q.smp + CW'(1);
         end
         // Cycle end: shift history, restart with no gap
         if (end_cyc) begin
            d.smp = '0;
            d.acc = '0;
            d.h1 = acc_nxt;
            d.h2 = q.h1;
            d.ncyc = (q.ncyc == acs_pkg::SINC_CYCLES) ? q.ncyc : q.ncyc + 2'h1;
         end
      end
      // Single run ends when the selected filter is done
      unique case (q.st)
         acs_pkg::ACS_IDLE: d.st = acs_pkg::ACS_IDLE;
         acs_pkg::ACS_SINGLE: begin
            if (sel_done) begin
               d.st = acs_pkg::ACS_IDLE;
            end
         end
         acs_pkg::ACS_CONT: d.st = acs_pkg::ACS_CONT;
         default: d.st = acs_pkg::ACS_IDLE;
      endcase
      // A mode write overrides any cycle end and restarts
      if (wr_mode) begin
         d.div = '0;
         d.smp = '0;
         d.acc = '0;
         d.h1 = '0;
         d.h2 = '0;
         d.ncyc = 2'h0;
         unique case (sfr_wdata[1:0])
            acs_pkg::MODE_SINGLE: d.st = acs_pkg::ACS_SINGLE;
            acs_pkg::MODE_CONT: d.st = acs_pkg::ACS_CONT;
            default: d.st = acs_pkg::ACS_IDLE;
         endcase
      end
      // Busy follows the state so it drops with idle
      d.busy = (d.st != acs_pkg::ACS_IDLE);
   end

   // State register, frozen while clock enable is low
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         q <= '0;
         q.st <= acs_pkg::ACS_IDLE;
         q.bufc <= acs_pkg::BUF_RST;
      end else if (ce) begin
         q <= d;
      end
   end

   // Outputs straight from flip-flops
   assign sfr_rdata = q.rdata;
   assign buf_ctrl = q.bufc;
   assign conv_busy = q.busy;

   // Checks on the sequencing
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   logic wr_stop; // Idle code written
   assign wr_stop = wr_mode && (sfr_wdata[1:0] != acs_pkg::MODE_SINGLE) && (sfr_wdata[1:0] != acs_pkg::MODE_CONT);

   a_busy_start: assert property (
      ce && wr_mode && sfr_wdata[1:0] == acs_pkg::MODE_SINGLE |=> conv_busy && q.st == acs_pkg::ACS_SINGLE)
      else $error("busy not raised after single start");

   a_done_select: assert property (
      ce && end_cyc && q.isel |=> q.done)
      else $error("done not set on fast result");

   a_fast_return: assert property (
      ce && q.st == acs_pkg::ACS_SINGLE && q.isel && end_cyc && !wr_mode
      |=> q.st == acs_pkg::ACS_IDLE && !conv_busy)
      else $error("single fast run did not return idle");

   a_sinc_wait: assert property (
      ce && q.st == acs_pkg::ACS_SINGLE && !q.isel && end_cyc && q.ncyc < 2'h2 && !wr_mode
      |=> q.st == acs_pkg::ACS_SINGLE && conv_busy && $stable(q.done))
      else $error("single SINC3 run ended early");

   a_buf_ignored: assert property (
      ce && wr_buf && q.st != acs_pkg::ACS_IDLE |=> $stable(buf_ctrl))
      else $error("buffer write accepted while busy");

   a_buf_idle_write: assert property (
      ce && wr_buf && q.st == acs_pkg::ACS_IDLE |=> buf_ctrl == $past(sfr_wdata))
      else $error("buffer write lost while idle");

   a_cont_no_gap: assert property (
      ce && q.st == acs_pkg::ACS_CONT && end_cyc && !wr_mode
      |=> q.st == acs_pkg::ACS_CONT && q.smp == '0 && conv_busy)
      else $error("continuous run stopped or gapped");

   a_stop_idle: assert property (
      ce && wr_stop |=> q.st == acs_pkg::ACS_IDLE ##1 !ce || !end_cyc)
      else $error("idle write did not stop conversions");

   a_sinc_three: assert property (
      ce && end_cyc && q.st == acs_pkg::ACS_CONT |-> sinc_if.load == (q.ncyc >= 2'h2))
      else $error("SINC3 load out of step");

   c_single_fast: cover property (ce && q.st == acs_pkg::ACS_SINGLE && q.isel && sel_done);
   c_single_sinc: cover property (ce && q.st == acs_pkg::ACS_SINGLE && !q.isel && sel_done);
   c_cont_sinc: cover property (ce && q.st == acs_pkg::ACS_CONT && sinc_if.load);
   c_buf_refused: cover property (ce && wr_buf && q.st != acs_pkg::ACS_IDLE);
endmodule : acs_sequencer

// ===== src/acs_sync.sv
// Two-stage synchroniser for the modulator data pin
`timescale 1ns/10ps
module acs_sync (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic d,
   output logic q
);
   // Both stages in one state word
   typedef struct packed {
      logic s1; // Metastable stage, read only by s2
      logic s2; // Settled stage
   } acs_sync_t;
   acs_sync_t st_q, st_d;

   // Shift the pin through both stages
   always_comb begin
      st_d = st_q;
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
   end

   // Frozen while clock enable is low
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_q <= {acs_pkg::SYNC_RST, acs_pkg::SYNC_RST};
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   assign q = st_q.s2;
endmodule : acs_sync

// ===== verification/acs_mod_model.sv
// Modulator stand-in that feeds a bit stream to the sequencer
`timescale 1ns/10ps
module acs_mod_model (
   input wire logic clk,
   input wire logic level, // Level the bench asks for
   output logic mod_bit // Modulator data pin
);
   // Steady level per stretch gives exact ones counts per cycle
   initial mod_bit = 1'b0;
   // Changes off the sampling edge; the sequencer resynchronises anyway
   always @(negedge clk) begin
      mod_bit <= level;
   end
endmodule : acs_mod_model

// ===== verification/adc_conversion_sequencer_tb.sv
// Self-checking testbench of the conversion sequencer
`timescale 1ns/10ps
module adc_conversion_sequencer_tb;
   localparam int MD = 2; // Clocks per sample, shortened
   localparam int DC = 4; // Samples per cycle, shortened
   localparam int CYC = MD * DC; // Clocks per conversion cycle
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic ce = 1'b1; // Clock enable, dropped once to check freezing
   logic level = 1'b0; // Modulator level
   logic mod_bit;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic [7:0] buf_ctrl;
   logic conv_busy;
   int num_errors = 0;
   int checks_done = 0;
   logic [7:0] rd; // Last byte read
   logic [7:0] rd2; // Earlier byte kept for relations
   logic [23:0] word; // Last result word read
   // Clock of 4 ns period
   always #2 clk = ~clk;
   acs_mod_model acs_mod_model_inst (.clk(clk), .level(level), .mod_bit(mod_bit));
   acs_sequencer #(.MOD_DIV(MD), .DECIM(DC)) acs_sequencer_inst (.clk(clk), .reset_n(reset_n), .ce(ce),
      .mod_bit(mod_bit), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .buf_ctrl(buf_ctrl), .conv_busy(conv_busy));
   // Verdict and end of run
   task automatic conclude();
      $display("Checks %0d, errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude
   task automatic chk_bit(input string n, input logic e, input logic g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %b seen %b", n, e, g);
      end
   endtask : chk_bit
   task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk_byte
   task automatic chk_word(input string n, input logic [23:0] e, input logic [23:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk_word
   // Waits whole cycles, always returning at a falling edge
   task automatic tick(input int n);
      sfr_wr = 1'b0;
      repeat (n) @(negedge clk);
   endtask : tick
   // Write strobe stays up for back-to-back writes; the next non-write task lowers it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk);
   endtask : wr
   // Read data is registered, so it is taken one edge later
   task automatic rd_reg(input logic [7:0] a);
      sfr_wr = 1'b0;
      sfr_addr = a;
      @(negedge clk);
      rd = sfr_rdata;
   endtask : rd_reg
   task automatic rd_res(input logic [7:0] ah, input logic [7:0] am, input logic [7:0] al);
      rd_reg(ah);
      word[23:16] = rd;
      rd_reg(am);
      word[15:8] = rd;
      rd_reg(al);
      word[7:0] = rd;
   endtask : rd_res
   // Busy is watched once per cycle over a span
   task automatic expect_busy(input int n, input logic v);
      sfr_wr = 1'b0;
      repeat (n) begin
         chk_bit("conv_busy", v, conv_busy);
         @(negedge clk);
      end
   endtask : expect_busy
   // Prepares done clear, polarity, filter select and input level
   task automatic setup(input logic [7:0] ctl, input logic [7:0] cfg, input logic lvl);
      wr(acs_pkg::ADDR_CTRL, ctl);
      wr(acs_pkg::ADDR_CFG, cfg);
      level = lvl;
      tick(4);
   endtask : setup
   // Reset values, including an unmapped address
   task automatic t_reset();
      logic [7:0] al [9];
      al = '{acs_pkg::ADDR_BUF, acs_pkg::ADDR_CTRL, acs_pkg::ADDR_CFG, acs_pkg::ADDR_MODE, acs_pkg::ADDR_SINC_H,
         acs_pkg::ADDR_SINC_L, acs_pkg::ADDR_FAST_H, acs_pkg::ADDR_FAST_L, 8'h01};
      chk_byte("buf_ctrl", acs_pkg::BUF_RST, buf_ctrl);
      chk_bit("conv_busy", 1'b0, conv_busy);
      foreach (al[i]) begin
         rd_reg(al[i]);
         chk_byte("reset read", 8'h00, rd);
      end
   endtask : t_reset
   // Buffer control written while idle takes effect
   task automatic t_buf_idle();
      wr(acs_pkg::ADDR_BUF, 8'hA5);
      chk_byte("buf_ctrl", 8'hA5, buf_ctrl);
      rd_reg(acs_pkg::ADDR_BUF);
      chk_byte("buf read", 8'hA5, rd);
   endtask : t_buf_idle
   // A buffer write while clock enable is low must leave the buffer register frozen
   task automatic t_freeze();
      ce = 1'b0;
      wr(acs_pkg::ADDR_BUF, 8'h5A);
      rd_reg(acs_pkg::ADDR_BUF);
      ce = 1'b1;
      chk_byte("buf_ctrl frozen", 8'hA5, buf_ctrl);
      rd_reg(acs_pkg::ADDR_BUF);
      chk_byte("buf read frozen", 8'hA5, rd);
   endtask : t_freeze
   // Single run on the fast filter, all ones, unipolar
   task automatic t_single_fast();
      setup(8'h00, 8'h01, 1'b1);
      wr(acs_pkg::ADDR_MODE, 8'h01);
      expect_busy(CYC, 1'b1);
      expect_busy(1, 1'b0);
      rd_res(acs_pkg::ADDR_FAST_H, acs_pkg::ADDR_FAST_M, acs_pkg::ADDR_FAST_L);
      chk_word("fast", 24'(DC), word);
      rd_reg(acs_pkg::ADDR_CTRL);
      chk_bit("done", 1'b1, rd[acs_pkg::CTRL_DONE_BIT]);
      rd_reg(acs_pkg::ADDR_MODE);
      chk_byte("mode", 8'h00, rd);
   endtask : t_single_fast
   // Single run on SINC3, all zeros, bipolar, buffer write refused
   task automatic t_single_sinc();
      setup(8'h04, 8'h00, 1'b0);
      wr(acs_pkg::ADDR_MODE, 8'h01);
      wr(acs_pkg::ADDR_BUF, 8'h3C);
      expect_busy(10, 1'b1);
      rd_reg(acs_pkg::ADDR_CTRL);
      chk_bit("done early", 1'b0, rd[acs_pkg::CTRL_DONE_BIT]);
      expect_busy(3 * CYC - 12, 1'b1);
      expect_busy(1, 1'b0);
      chk_byte("buf_ctrl", 8'hA5, buf_ctrl);
      rd_res(acs_pkg::ADDR_FAST_H, acs_pkg::ADDR_FAST_M, acs_pkg::ADDR_FAST_L);
      chk_word("fast bipolar", 24'(-DC), word);
      rd_res(acs_pkg::ADDR_SINC_H, acs_pkg::ADDR_SINC_M, acs_pkg::ADDR_SINC_L);
      chk_word("sinc bipolar", 24'(-3 * DC), word);
      rd_reg(acs_pkg::ADDR_CTRL);
      chk_bit("done", 1'b1, rd[acs_pkg::CTRL_DONE_BIT]);
   endtask : t_single_sinc
   // Continuous on the fast filter, then stopped with the idle code
   task automatic t_cont();
      setup(8'h00, 8'h01, 1'b1);
      wr(acs_pkg::ADDR_MODE, 8'h02);
      expect_busy(5 * CYC, 1'b1);
      rd_res(acs_pkg::ADDR_SINC_H, acs_pkg::ADDR_SINC_M, acs_pkg::ADDR_SINC_L);
      chk_word("sinc", 24'(3 * DC), word);
      rd_res(acs_pkg::ADDR_FAST_H, acs_pkg::ADDR_FAST_M, acs_pkg::ADDR_FAST_L);
      chk_word("fast", 24'(DC), word);
      wr(acs_pkg::ADDR_MODE, 8'h00);
      expect_busy(2 * CYC, 1'b0);
      rd_reg(acs_pkg::ADDR_MODE);
      chk_byte("mode", 8'h00, rd);
   endtask : t_cont
   // First SINC3 load only after the third cycle; code 3 stops
   task automatic t_first_sinc();
      setup(8'h00, 8'h00, 1'b0);
      wr(acs_pkg::ADDR_MODE, 8'h02);
      tick(2 * CYC);
      rd_res(acs_pkg::ADDR_SINC_H, acs_pkg::ADDR_SINC_M, acs_pkg::ADDR_SINC_L);
      chk_word("sinc held", 24'(3 * DC), word);
      rd_res(acs_pkg::ADDR_FAST_H, acs_pkg::ADDR_FAST_M, acs_pkg::ADDR_FAST_L);
      chk_word("fast", 24'h000000, word);
      rd_reg(acs_pkg::ADDR_CTRL);
      chk_bit("done early", 1'b0, rd[acs_pkg::CTRL_DONE_BIT]);
      tick(CYC);
      rd_res(acs_pkg::ADDR_SINC_H, acs_pkg::ADDR_SINC_M, acs_pkg::ADDR_SINC_L);
      chk_word("sinc", 24'h000000, word);
      wr(acs_pkg::ADDR_MODE, 8'h03);
      expect_busy(CYC, 1'b0);
   endtask : t_first_sinc
   // Step from ones to zeros: SINC3 keeps three cycles of history
   task automatic t_step();
      setup(8'h00, 8'h01, 1'b1);
      wr(acs_pkg::ADDR_MODE, 8'h02);
      tick(3 * CYC);
      level = 1'b0;
      tick(CYC);
      rd_reg(acs_pkg::ADDR_SINC_L);
      rd2 = rd;
      rd_reg(acs_pkg::ADDR_FAST_L);
      chk_byte("sinc step", rd + 8'(2 * DC), rd2);
      tick(3 * CYC);
      rd_reg(acs_pkg::ADDR_SINC_L);
      chk_byte("sinc settled", 8'h00, rd);
      wr(acs_pkg::ADDR_MODE, 8'h00);
   endtask : t_step
   // Main sequence: reset for four cycles, then the scenarios
   initial begin
      tick(4);
      reset_n = 1'b1;
      t_reset();
      t_buf_idle();
      t_freeze();
      t_single_fast();
      t_single_sinc();
      t_cont();
      t_first_sinc();
      t_step();
      tick(4);
      conclude();
   end
   // Watchdog well beyond the roughly 270 cycles the scenarios take
   initial begin
      #20000;
      num_errors++;
      $display("ERROR watchdog expected finish seen hang");
      conclude();
   end
endmodule : adc_conversion_sequencer_tb
